// ==== ricr_regs.sv ====
// Paged control and status registers for the record path analog front end
//
// Functional notes
// - Bias bit 7 enables software power-down.
// - Bias bit 3 forces bias despite headset.
// - Bias level: off, 2 V, 2.5 V, rail.
// - Gain bit 7 forces amplifier to 0 dB.
// - Gain code in half-dB steps to 59.5; codes above 119 pass through unclamped, up to 63.5.
// - Positive bits 7:6 route voice input.
// - Positive bits 5:4 route spare input a.
// - Positive bits 3:2 route spare input b.
// - Negative bits 7:6 route common-mode reference.
// - Negative bits 5:4 route spare input b.
// - Tie bit 7 ties idle voice input.
// - Tie bit 6 ties idle spare input a.
// - Tie bit 5 ties idle spare input b.
// - Tie bit 0 reads gains applied.
// - Index 0 selects page; page 1 here.
`include "ricr_defs.svh"

module ricr_regs #(
   parameter int SETTLE_NS = `RICR_SETTLE_NS
) (
   input  wire logic                     ref_clk,
   input  wire logic                     arst_n,
   input  wire logic                     reg_wr_en,
   input  wire logic                     reg_rd_en,
   input  wire logic [`RICR_IDX_W-1:0]   reg_idx,
   input  wire logic [`RICR_DATA_W-1:0]  reg_wdata,
   output logic      [`RICR_DATA_W-1:0]  reg_rdata,
   output logic                          reg_rd_valid,
   input  wire logic                     headset_det_en,
   input  wire logic                     headset_inserted,
   input  wire logic                     bypass_uses_voice,
   input  wire logic                     bypass_uses_spare_a,
   output logic                          soft_pwdn_en,
   output logic                          voice_bias_on,
   output ricr_pkg::ricr_bias_t          voice_bias_level,
   output logic      [6:0]               gain_half_db,
   output ricr_pkg::ricr_res_t           voice_input_pin_res,
   output ricr_pkg::ricr_res_t           spare_input_a_res,
   output ricr_pkg::ricr_res_t           spare_input_b_pos_res,
   output ricr_pkg::ricr_res_t           common_mode_ref_res,
   output ricr_pkg::ricr_res_t           spare_input_b_neg_res,
   output logic                          voice_input_pin_tie,
   output logic                          spare_input_a_tie,
   output logic                          spare_input_b_tie,
   output logic                          gain_applied
);
   // Least time, rounded up to whole cycles
   localparam int SETTLE_CYC =
      (SETTLE_NS * `RICR_PS_PER_NS + `RICR_CLK_PERIOD_PS - 1) / `RICR_CLK_PERIOD_PS;

   function automatic logic res_used(input logic [1:0] code);
      return code != 2'(ricr_pkg::RICR_RES_OPEN);
   endfunction

   // ---------------- register file ----------------
   logic [7:0] page;
   logic [7:0] rsvd45;
   logic [7:0] voice_bias_control;
   logic [7:0] input_gain_amp_ctrl;
   logic [7:0] pos_input_routing;
   logic [7:0] neg_input_routing;
   logic [7:0] unused_input_tie;
   logic [7:0] next_page;
   logic [7:0] next_rsvd45;
   logic [7:0] next_bias;
   logic [7:0] next_gain;
   logic [7:0] next_pos;
   logic [7:0] next_neg;
   logic [7:0] next_tie;
   logic       on_page;
   logic       analog_wr;

   assign on_page = page == `RICR_PAGE_THIS;

   always_comb begin
      next_page   = page;
      next_rsvd45 = rsvd45;
      next_bias   = voice_bias_control;
      next_gain   = input_gain_amp_ctrl;
      next_pos    = pos_input_routing;
      next_neg    = neg_input_routing;
      next_tie    = unused_input_tie;
      analog_wr   = 1'b0;
      if (reg_wr_en) begin
         if (reg_idx == `RICR_IDX_PAGE) begin
            next_page = reg_wdata;
         end else if (on_page) begin
            unique case (reg_idx)
               `RICR_IDX_RSVD45: next_rsvd45 = reg_wdata;
               `RICR_IDX_BIAS:   next_bias   = reg_wdata;
               `RICR_IDX_GAIN: begin
                  next_gain = reg_wdata;
                  analog_wr = 1'b1;
               end
               `RICR_IDX_POS: begin
                  next_pos  = reg_wdata;
                  analog_wr = 1'b1;
               end
               `RICR_IDX_NEG: begin
                  next_neg  = reg_wdata;
                  analog_wr = 1'b1;
               end
               // Flag bit is status only, never stored
               `RICR_IDX_TIE: begin
                  next_tie[`RICR_TIE_WR_HI:`RICR_TIE_WR_LO] = reg_wdata[`RICR_TIE_WR_HI:`RICR_TIE_WR_LO];
               end
               default: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         page                <= `RICR_RST_PAGE;
         rsvd45              <= `RICR_RST_RSVD45;
         voice_bias_control  <= `RICR_RST_BIAS;
         input_gain_amp_ctrl <= `RICR_RST_GAIN;
         pos_input_routing   <= `RICR_RST_POS;
         neg_input_routing   <= `RICR_RST_NEG;
         unused_input_tie    <= `RICR_RST_TIE;
      end else begin
         page                <= next_page;
         rsvd45              <= next_rsvd45;
         voice_bias_control  <= next_bias;
         input_gain_amp_ctrl <= next_gain;
         pos_input_routing   <= next_pos;
         neg_input_routing   <= next_neg;
         unused_input_tie    <= next_tie;
      end
   end

   // ---------------- gain-applied status ----------------
   // gain and routing writes restart settling; bias, tie and page writes do not
   ricr_settle #(
      .SETTLE_CYC (SETTLE_CYC)
   ) u_settle (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .restart (analog_wr),
      .settled (gain_applied)
   );

   // ---------------- read port ----------------
   logic [7:0] next_rdata;
   logic       next_rd_valid;

   always_comb begin
      next_rdata    = `RICR_ZERO8;
      next_rd_valid = reg_rd_en;
      if (reg_rd_en) begin
         if (reg_idx == `RICR_IDX_PAGE) begin
            next_rdata = page;
         end else if (on_page) begin
            unique case (reg_idx)
               `RICR_IDX_RSVD45: next_rdata = rsvd45;
               `RICR_IDX_BIAS:   next_rdata = voice_bias_control;
               `RICR_IDX_GAIN:   next_rdata = input_gain_amp_ctrl;
               `RICR_IDX_POS:    next_rdata = pos_input_routing;
               `RICR_IDX_NEG:    next_rdata = neg_input_routing;
               // live applied flag in bit 0
               `RICR_IDX_TIE: begin
                  next_rdata                    = unused_input_tie;
                  next_rdata[`RICR_TIE_FLAG_BIT] = gain_applied;
               end
               default:          next_rdata = `RICR_ZERO8;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata    <= `RICR_ZERO8;
         reg_rd_valid <= 1'b0;
      end else begin
         reg_rdata    <= next_rdata;
         reg_rd_valid <= next_rd_valid;
      end
   end

   // ---------------- headset pin synchroniser ----------------
   // Third stage filters one-cycle glitches on the detector pin
   logic hs_s1;
   logic hs_s2;
   logic hs_s3;
   logic hs_stable;
   logic next_hs_stable;

   always_comb begin
      next_hs_stable = hs_stable;
      if (hs_s2 == hs_s3) begin
         next_hs_stable = hs_s3;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         hs_s1     <= 1'b0;
         hs_s2     <= 1'b0;
         hs_s3     <= 1'b0;
         hs_stable <= 1'b0;
      end else begin
         hs_s1     <= headset_inserted;
         hs_s2     <= hs_s1;
         hs_s3     <= hs_s2;
         hs_stable <= next_hs_stable;
      end
   end

   // ---------------- analog control outputs ----------------
   logic                 next_pwdn;
   logic                 next_bias_on;
   ricr_pkg::ricr_bias_t next_bias_lvl;
   logic [6:0]           next_gain_hdb;
   logic                 next_voice_tie;
   logic                 next_spa_tie;
   logic                 next_spb_tie;
   logic                 bias_blocked;

   always_comb begin
      next_pwdn = voice_bias_control[`RICR_BIAS_PWDN_BIT];
      bias_blocked = headset_det_en && !hs_stable && !voice_bias_control[`RICR_BIAS_FORCE_BIT];
      next_bias_lvl = ricr_pkg::ricr_bias_t'(voice_bias_control[`RICR_BIAS_LVL_HI:`RICR_BIAS_LVL_LO]);
      if (bias_blocked) begin
         next_bias_lvl = ricr_pkg::RICR_BIAS_OFF;
      end
      next_bias_on = next_bias_lvl != ricr_pkg::RICR_BIAS_OFF;
      next_gain_hdb = input_gain_amp_ctrl[`RICR_GAIN_FORCE_BIT] ? `RICR_GAIN_ZERO
                      : input_gain_amp_ctrl[`RICR_GAIN_CODE_HI:`RICR_GAIN_CODE_LO];
      next_voice_tie = unused_input_tie[`RICR_TIE_VOICE_BIT] && !bypass_uses_voice
                       && !res_used(pos_input_routing[`RICR_POS_VOICE_HI:`RICR_POS_VOICE_LO]);
      next_spa_tie = unused_input_tie[`RICR_TIE_SPA_BIT] && !bypass_uses_spare_a
                     && !res_used(pos_input_routing[`RICR_POS_SPA_HI:`RICR_POS_SPA_LO]);
      next_spb_tie = unused_input_tie[`RICR_TIE_SPB_BIT]
                     && !res_used(pos_input_routing[`RICR_POS_SPB_HI:`RICR_POS_SPB_LO])
                     && !res_used(neg_input_routing[`RICR_NEG_SPB_HI:`RICR_NEG_SPB_LO]);
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         soft_pwdn_en        <= 1'b0;
         voice_bias_on       <= 1'b0;
         voice_bias_level    <= ricr_pkg::RICR_BIAS_OFF;
         gain_half_db        <= `RICR_GAIN_ZERO;
         voice_input_pin_tie <= 1'b0;
         spare_input_a_tie   <= 1'b0;
         spare_input_b_tie   <= 1'b0;
      end else begin
         soft_pwdn_en        <= next_pwdn;
         voice_bias_on       <= next_bias_on;
         voice_bias_level    <= next_bias_lvl;
         gain_half_db        <= next_gain_hdb;
         voice_input_pin_tie <= next_voice_tie;
         spare_input_a_tie   <= next_spa_tie;
         spare_input_b_tie   <= next_spb_tie;
      end
   end

   assign voice_input_pin_res   = ricr_pkg::ricr_res_t'(pos_input_routing[`RICR_POS_VOICE_HI:`RICR_POS_VOICE_LO]);
   assign spare_input_a_res     = ricr_pkg::ricr_res_t'(pos_input_routing[`RICR_POS_SPA_HI:`RICR_POS_SPA_LO]);
   assign spare_input_b_pos_res = ricr_pkg::ricr_res_t'(pos_input_routing[`RICR_POS_SPB_HI:`RICR_POS_SPB_LO]);
   assign common_mode_ref_res   = ricr_pkg::ricr_res_t'(neg_input_routing[`RICR_NEG_CM_HI:`RICR_NEG_CM_LO]);
   assign spare_input_b_neg_res = ricr_pkg::ricr_res_t'(neg_input_routing[`RICR_NEG_SPB_HI:`RICR_NEG_SPB_LO]);

   // ---------------- checks ----------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   sequence page_wr_s(logic [6:0] idx);
      reg_wr_en && on_page && reg_idx == idx;
   endsequence

   sequence analog_wr_s;
      page_wr_s(`RICR_IDX_GAIN) or page_wr_s(`RICR_IDX_POS) or page_wr_s(`RICR_IDX_NEG);
   endsequence

   page_select_a : assert property (reg_wr_en && reg_idx == `RICR_IDX_PAGE |=> page == $past(reg_wdata))
      else $error("page register did not take written value");
   off_page_a : assert property (reg_wr_en && !on_page && reg_idx == `RICR_IDX_GAIN
                                 |=> $stable(input_gain_amp_ctrl))
      else $error("gain register changed while another page selected");
   pwdn_follow_a : assert property (page_wr_s(`RICR_IDX_BIAS) |=> ##1 soft_pwdn_en == $past(reg_wdata[7], 2))
      else $error("power-down output does not follow bias bit 7");
   bias_gate_a : assert property (headset_det_en && !hs_stable && !voice_bias_control[3] |=> !voice_bias_on)
      else $error("bias on while headset absent and not forced");
   bias_level_a : assert property (!bias_blocked
                                   |=> voice_bias_level == $past(voice_bias_control[`RICR_BIAS_LVL_HI:`RICR_BIAS_LVL_LO])
                                   && voice_bias_on == ($past(voice_bias_control[`RICR_BIAS_LVL_HI:`RICR_BIAS_LVL_LO])
                                                        != 2'b00))
      else $error("bias level or power state does not follow level field");
   gain_force_a : assert property (input_gain_amp_ctrl[7] |=> gain_half_db == `RICR_GAIN_ZERO)
      else $error("forced gain not at zero");
   gain_code_a : assert property (!input_gain_amp_ctrl[7] |=> gain_half_db == $past(input_gain_amp_ctrl[6:0]))
      else $error("gain output does not follow code");
   route_pos_a : assert property (page_wr_s(`RICR_IDX_POS) |=> voice_input_pin_res == $past(reg_wdata[7:6])
                                  && spare_input_a_res == $past(reg_wdata[5:4]))
      else $error("positive routing not updated");
   route_neg_a : assert property (page_wr_s(`RICR_IDX_NEG) |=> common_mode_ref_res == $past(reg_wdata[7:6])
                                  && spare_input_b_neg_res == $past(reg_wdata[5:4]))
      else $error("negative routing not updated");
   voice_tie_a : assert property (voice_input_pin_tie |-> $past(unused_input_tie[7]) && !$past(bypass_uses_voice))
      else $error("voice input tied while disabled or in bypass");
   spb_tie_a : assert property (spare_input_b_tie |-> $past(neg_input_routing[5:4]) == 2'b00)
      else $error("spare b tied while routed to negative terminal");
   flag_clear_a : assert property (analog_wr_s |=> !gain_applied ##1 !gain_applied)
      else $error("applied flag not cleared by analog write");
   flag_read_a : assert property (reg_rd_en && on_page && reg_idx == `RICR_IDX_TIE
                                  |=> reg_rd_valid && reg_rdata[0] == $past(gain_applied))
      else $error("applied flag misread");
endmodule

// ==== ricr_defs.svh ====
// Register indices, field positions, reset values and timing for the record input block
`ifndef RICR_DEFS_SVH
`define RICR_DEFS_SVH

`define RICR_IDX_W          7
`define RICR_DATA_W         8
`define RICR_IDX_PAGE       7'h00
`define RICR_IDX_RSVD45     7'h2d
`define RICR_IDX_BIAS       7'h2e
`define RICR_IDX_GAIN       7'h2f
`define RICR_IDX_POS        7'h30
`define RICR_IDX_NEG        7'h31
`define RICR_IDX_TIE        7'h32
`define RICR_PAGE_THIS      8'h01

`define RICR_RST_PAGE       8'h00
`define RICR_RST_RSVD45     8'h00
`define RICR_RST_BIAS       8'h00
`define RICR_RST_GAIN       8'h80
`define RICR_RST_POS        8'h00
`define RICR_RST_NEG        8'h00
`define RICR_RST_TIE        8'h00
`define RICR_ZERO8          8'h00

`define RICR_BIAS_PWDN_BIT  7
`define RICR_BIAS_FORCE_BIT 3
`define RICR_BIAS_LVL_HI    1
`define RICR_BIAS_LVL_LO    0
`define RICR_GAIN_FORCE_BIT 7
`define RICR_GAIN_CODE_HI   6
`define RICR_GAIN_CODE_LO   0
`define RICR_POS_VOICE_HI   7
`define RICR_POS_VOICE_LO   6
`define RICR_POS_SPA_HI     5
`define RICR_POS_SPA_LO     4
`define RICR_POS_SPB_HI     3
`define RICR_POS_SPB_LO     2
`define RICR_NEG_CM_HI      7
`define RICR_NEG_CM_LO      6
`define RICR_NEG_SPB_HI     5
`define RICR_NEG_SPB_LO     4
`define RICR_TIE_VOICE_BIT  7
`define RICR_TIE_SPA_BIT    6
`define RICR_TIE_SPB_BIT    5
`define RICR_TIE_FLAG_BIT   0
`define RICR_TIE_WR_HI      7
`define RICR_TIE_WR_LO      1

`define RICR_GAIN_ZERO      7'h00
`define RICR_CLK_PERIOD_PS  4000
`define RICR_PS_PER_NS      1000
`define RICR_SETTLE_NS      1000

`endif

// ==== ricr_pkg.sv ====
// Types shared by the record input configuration block
package ricr_pkg;
   typedef enum logic [1:0] {
      RICR_BIAS_OFF,
      RICR_BIAS_2V0,
      RICR_BIAS_2V5,
      RICR_BIAS_RAIL
   } ricr_bias_t;

   typedef enum logic [1:0] {
      RICR_RES_OPEN,
      RICR_RES_10K,
      RICR_RES_20K,
      RICR_RES_40K
   } ricr_res_t;

   typedef enum {
      RICR_ST_IDLE,
      RICR_ST_WAIT
   } ricr_settle_t;
endpackage

// ==== ricr_settle.sv ====
// Settling timer that reports when new analog gain settings have taken effect
`include "ricr_defs.svh"

module ricr_settle #(
   parameter int SETTLE_CYC = 250
) (
   input  wire logic ref_clk,
   input  wire logic arst_n,
   input  wire logic restart,
   output logic      settled
);
   localparam int CW = $clog2(SETTLE_CYC + 1);

   ricr_pkg::ricr_settle_t state;
   ricr_pkg::ricr_settle_t next_state;
   logic [CW-1:0]          cnt;
   logic [CW-1:0]          next_cnt;
   logic                   next_settled;

   always_comb begin
      next_state   = state;
      next_cnt     = cnt;
      next_settled = settled;
      // A new write restarts the wait even mid count
      if (restart) begin
         next_state   = ricr_pkg::RICR_ST_WAIT;
         next_cnt     = CW'(SETTLE_CYC - 1);
         next_settled = 1'b0;
      end else begin
         unique case (state)
            ricr_pkg::RICR_ST_IDLE: begin
               next_settled = 1'b1;
            end
            ricr_pkg::RICR_ST_WAIT: begin
               if (cnt == '0) begin
                  next_state   = ricr_pkg::RICR_ST_IDLE;
                  next_settled = 1'b1;
               end else begin
                  next_cnt = cnt - CW'(1);
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state   <= ricr_pkg::RICR_ST_WAIT;
         cnt     <= CW'(SETTLE_CYC - 1);
         settled <= 1'b0;
      end else begin
         state   <= next_state;
         cnt     <= next_cnt;
         settled <= next_settled;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   settle_hold_a : assert property (restart |=> !settled [*2])
      else $error("settled flag rose too soon after restart");
   settle_time_a : assert property ($rose(settled) |-> $past(state) == ricr_pkg::RICR_ST_WAIT)
      else $error("settled flag rose without a finished wait");
endmodule

// ==== test_record_input_config_regs.sv ====
// Self-checking bench for the record input configuration registers
`include "ricr_defs.svh"

module test_record_input_config_regs;
   timeunit 1ns;
   timeprecision 1ps;

   // Short settle time keeps the waits for the applied flag brief
   localparam int SETTLE_NS = 8;
   localparam int WAIT_MAX  = 40;
   localparam int CYC_MAX   = 5000;

   logic                       ref_clk;
   logic                       arst_n;
   logic                       reg_wr_en;
   logic                       reg_rd_en;
   logic [`RICR_IDX_W-1:0]     reg_idx;
   logic [`RICR_DATA_W-1:0]    reg_wdata;
   logic [`RICR_DATA_W-1:0]    reg_rdata;
   logic                       reg_rd_valid;
   logic                       headset_det_en;
   logic                       headset_inserted;
   logic                       bypass_uses_voice;
   logic                       bypass_uses_spare_a;
   logic                       soft_pwdn_en;
   logic                       voice_bias_on;
   ricr_pkg::ricr_bias_t       voice_bias_level;
   logic [6:0]                 gain_half_db;
   ricr_pkg::ricr_res_t        voice_input_pin_res;
   ricr_pkg::ricr_res_t        spare_input_a_res;
   ricr_pkg::ricr_res_t        spare_input_b_pos_res;
   ricr_pkg::ricr_res_t        common_mode_ref_res;
   ricr_pkg::ricr_res_t        spare_input_b_neg_res;
   logic                       voice_input_pin_tie;
   logic                       spare_input_a_tie;
   logic                       spare_input_b_tie;
   logic                       gain_applied;
   int                         mismatches;
   int                         tests_run;
   int                         cycles;
   logic [7:0]                 gains [5];

   ricr_regs #(.SETTLE_NS(SETTLE_NS)) ricr_regs_i (
      .ref_clk               (ref_clk),
      .arst_n                (arst_n),
      .reg_wr_en             (reg_wr_en),
      .reg_rd_en             (reg_rd_en),
      .reg_idx               (reg_idx),
      .reg_wdata             (reg_wdata),
      .reg_rdata             (reg_rdata),
      .reg_rd_valid          (reg_rd_valid),
      .headset_det_en        (headset_det_en),
      .headset_inserted      (headset_inserted),
      .bypass_uses_voice     (bypass_uses_voice),
      .bypass_uses_spare_a   (bypass_uses_spare_a),
      .soft_pwdn_en          (soft_pwdn_en),
      .voice_bias_on         (voice_bias_on),
      .voice_bias_level      (voice_bias_level),
      .gain_half_db          (gain_half_db),
      .voice_input_pin_res   (voice_input_pin_res),
      .spare_input_a_res     (spare_input_a_res),
      .spare_input_b_pos_res (spare_input_b_pos_res),
      .common_mode_ref_res   (common_mode_ref_res),
      .spare_input_b_neg_res (spare_input_b_neg_res),
      .voice_input_pin_tie   (voice_input_pin_tie),
      .spare_input_a_tie     (spare_input_a_tie),
      .spare_input_b_tie     (spare_input_b_tie),
      .gain_applied          (gain_applied)
   );

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == CYC_MAX) begin
         mismatches++;
         complete_run();
      end
   end

   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t ns got %h expected %h", $time, got, exp);
      end
   endtask

   // Strobe lowered on its own edge, so back-to-back calls never clash
   task automatic wr(input logic [6:0] idx, input logic [7:0] data);
      @(posedge ref_clk);
      reg_wr_en <= 1'b1;
      reg_idx   <= idx;
      reg_wdata <= data;
      @(posedge ref_clk);
      reg_wr_en <= 1'b0;
      #1;
   endtask

   task automatic chk_rd(input logic [6:0] idx, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_rd_en <= 1'b1;
      reg_idx   <= idx;
      @(posedge ref_clk);
      reg_rd_en <= 1'b0;
      #1;
      chk_val({7'h00, reg_rd_valid}, 8'h01);
      chk_val(reg_rdata, exp);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic set_env(input logic det, input logic ins, input logic bv, input logic ba);
      @(posedge ref_clk);
      headset_det_en      <= det;
      headset_inserted    <= ins;
      bypass_uses_voice   <= bv;
      bypass_uses_spare_a <= ba;
   endtask

   task automatic wait_applied();
      int n;
      n = 0;
      while (gain_applied !== 1'b1 && n < WAIT_MAX) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk_val({7'h00, gain_applied}, 8'h01);
   endtask

   task automatic chk_ties(input logic [2:0] exp);
      chk_val({5'h00, voice_input_pin_tie, spare_input_a_tie, spare_input_b_tie}, {5'h00, exp});
   endtask

   initial begin
      arst_n = 1'b0;
      {reg_wr_en, reg_rd_en, reg_idx, reg_wdata} = '0;
      {headset_det_en, headset_inserted, bypass_uses_voice, bypass_uses_spare_a} = '0;
      mismatches = 0;
      tests_run  = 0;
      cycles     = 0;
      gains      = '{8'h0a, 8'h77, 8'h00, 8'hf7, 8'h01};
      repeat (10) @(posedge ref_clk);
      arst_n <= 1'b1;

      chk_rd(`RICR_IDX_PAGE, `RICR_RST_PAGE);
      chk_rd(`RICR_IDX_GAIN, `RICR_ZERO8);
      wr(`RICR_IDX_PAGE, `RICR_PAGE_THIS);
      chk_rd(`RICR_IDX_PAGE, `RICR_PAGE_THIS);
      chk_rd(`RICR_IDX_BIAS, `RICR_RST_BIAS);
      chk_rd(`RICR_IDX_GAIN, `RICR_RST_GAIN);
      chk_rd(`RICR_IDX_POS, `RICR_RST_POS);
      chk_rd(`RICR_IDX_NEG, `RICR_RST_NEG);
      chk_rd(`RICR_IDX_RSVD45, `RICR_RST_RSVD45);
      chk_val({1'b0, gain_half_db}, 8'h00);
      wait_applied();
      chk_rd(`RICR_IDX_TIE, 8'h01);
      chk_rd(7'h40, `RICR_ZERO8);
      $display("test reset_and_page done");

      foreach (gains[i]) begin
         wr(`RICR_IDX_GAIN, gains[i]);
         chk_val({7'h00, gain_applied}, 8'h00);
         tick(1);
         chk_val({1'b0, gain_half_db}, gains[i][7] ? 8'h00 : {1'b0, gains[i][6:0]});
         wait_applied();
         chk_rd(`RICR_IDX_GAIN, gains[i]);
      end
      $display("test gain done");

      for (int l = 0; l < 4; l++) begin
         wr(`RICR_IDX_BIAS, 8'h88 | l[7:0]);
         chk_val({7'h00, gain_applied}, 8'h01);
         tick(1);
         chk_val({6'h00, voice_bias_level}, l[7:0]);
         chk_val({7'h00, voice_bias_on}, {7'h00, l != 0});
         chk_val({7'h00, soft_pwdn_en}, 8'h01);
      end
      set_env(1'b1, 1'b0, 1'b0, 1'b0);
      wr(`RICR_IDX_BIAS, 8'h01);
      tick(1);
      chk_val({6'h00, voice_bias_level, voice_bias_on}, 8'h00);
      chk_val({7'h00, soft_pwdn_en}, 8'h00);
      set_env(1'b1, 1'b1, 1'b0, 1'b0);
      tick(8);
      chk_val({6'h00, voice_bias_level, voice_bias_on}, 8'h03);
      set_env(1'b1, 1'b0, 1'b0, 1'b0);
      tick(8);
      chk_val({6'h00, voice_bias_level, voice_bias_on}, 8'h00);
      wr(`RICR_IDX_BIAS, 8'h0a);
      tick(1);
      chk_val({6'h00, voice_bias_level, voice_bias_on}, 8'h05);
      $display("test bias done");

      for (int c = 0; c < 4; c++) begin
         wr(`RICR_IDX_POS, {c[1:0], ~c[1:0], c[1:0], 2'b00});
         wr(`RICR_IDX_NEG, {~c[1:0], c[1:0], 4'h0});
         chk_val({7'h00, gain_applied}, 8'h00);
         chk_val({6'h00, voice_input_pin_res}, {6'h00, c[1:0]});
         chk_val({6'h00, spare_input_a_res}, {6'h00, ~c[1:0]});
         chk_val({6'h00, spare_input_b_pos_res}, {6'h00, c[1:0]});
         chk_val({6'h00, common_mode_ref_res}, {6'h00, ~c[1:0]});
         chk_val({6'h00, spare_input_b_neg_res}, {6'h00, c[1:0]});
         wait_applied();
      end
      $display("test routing done");

      set_env(1'b0, 1'b0, 1'b0, 1'b0);
      wr(`RICR_IDX_POS, 8'h00);
      wr(`RICR_IDX_NEG, 8'h00);
      wr(`RICR_IDX_TIE, 8'he0);
      tick(1);
      chk_ties(3'b111);
      wait_applied();
      chk_rd(`RICR_IDX_TIE, 8'he1);
      set_env(1'b0, 1'b0, 1'b1, 1'b1);
      tick(2);
      chk_ties(3'b001);
      set_env(1'b0, 1'b0, 1'b0, 1'b0);
      wr(`RICR_IDX_POS, 8'h44);
      tick(1);
      chk_ties(3'b010);
      wr(`RICR_IDX_POS, 8'h10);
      wr(`RICR_IDX_NEG, 8'h10);
      tick(1);
      chk_ties(3'b100);
      wr(`RICR_IDX_TIE, 8'h00);
      tick(1);
      chk_ties(3'b000);
      $display("test tie done");

      wr(`RICR_IDX_PAGE, 8'h00);
      wr(`RICR_IDX_GAIN, 8'h05);
      chk_rd(`RICR_IDX_GAIN, `RICR_ZERO8);
      chk_rd(`RICR_IDX_PAGE, 8'h00);
      wr(`RICR_IDX_PAGE, `RICR_PAGE_THIS);
      chk_rd(`RICR_IDX_GAIN, 8'h01);
      $display("test paging done");

      complete_run();
   end
endmodule
